/* File: rtl/ptc_regs.sv */
// Power, tone and auxiliary command registers with checksum bytes.
// Assumes a Wishbone classic master, a checksum engine driving the computed
// checksum, and a link that flags the start and end of each received
// transaction with one-cycle pulses.
// Reads have no side effect except clearing the hard reinit tone request.
// Checksum bytes are plain flops; retention across power loss is left to the wrapper.
// Only byte lane 0 carries register data; the other lanes are ignored.
//
// Function
// - A soft reset command reloads the register defaults and its bit clears itself.
// - A soft reset command also sends a wake tone up the stack.
// - With the address arm bit set, the first received transaction is not forwarded.
// - With the address arm bit clear, every received transaction is forwarded.
// - Among power bits written together only the highest runs: soft reset, power down, doze.
// - Tones rank wake, doze to active, off or hard reinit, and any power bit beats any tone.
// - Writing the hard reinit tone bit sends that tone and a read of the register clears it.
// - The thermistor bias enable bit turns the bias regulator on or off.
// - The host checksum high byte is held in its own plain register.
// - The host checksum low byte is held in a second plain register.
// - The computed checksum high byte is readable in a read-only register.
// - The computed checksum low byte is readable in a read-only register.
`timescale 1ns/1ps
module ptc_regs
  import ptc_pkg::*;
#(
  parameter logic [7:0] HOST_CK_HI_DEF = RST_HOST_CK_HI,
  parameter logic [7:0] HOST_CK_LO_DEF = RST_HOST_CK_LO
)
(
  input wire logic clk_i,                       // System clock
  input wire logic rst_i,                       // Synchronous reset, high
  input wire logic wb_cyc_i,                    // Bus cycle
  input wire logic wb_stb_i,                    // Strobe
  input wire logic wb_we_i,                     // Write enable
  input wire logic [ADR_W-1:0] wb_adr_i,        // Byte address
  input wire logic [3:0] wb_sel_i,              // Byte lanes
  input wire logic [31:0] wb_dat_i,             // Write data
  output logic [31:0] wb_dat_o,                 // Read data
  output logic wb_ack_o,                        // Acknowledge
  input wire logic [7:0] calc_ck_hi_i,          // Computed checksum high
  input wire logic [7:0] calc_ck_lo_i,          // Computed checksum low
  input wire logic rx_start_i,                  // Received transaction starts
  input wire logic rx_end_i,                    // Received transaction ends
  output logic forward_en_o,                    // Forward received traffic
  output ptc_tone_t tone_o,                     // Tone request pulses
  output ptc_power_t power_o,                   // Power command pulses
  output logic thermistor_bias_enable_o,        // Bias regulator on
  output logic dir_sel_o,                       // Chain direction select
  output logic [7:0] host_ck_hi_o,              // Host checksum high
  output logic [7:0] host_ck_lo_o               // Host checksum low
);

  // All state lives in one registered struct
  ptc_state_t st;
  ptc_state_t next_st;

  logic req;
  logic low_lane;
  logic wr;
  logic rd;
  logic [IDX_W-1:0] idx;
  logic hit_ck_hi;
  logic hit_ck_lo;
  logic hit_pwr;
  logic hit_aux;
  logic hit_calc_hi;
  logic hit_calc_lo;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic pwr_any;
  logic wr_pwr;
  logic wr_aux;
  logic adr_ok;

  // Decode; upper address bits must be zero for a hit
  // Ack is registered, so a request held through its ack cycle is taken only once
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign low_lane = wb_sel_i[0];
  assign idx = wb_adr_i[IDX_W+1:2];
  assign adr_ok = (wb_adr_i[ADR_W-1:IDX_W+2] == '0);
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign hit_ck_hi = adr_ok && (idx == IDX_HOST_CK_HI);
  assign hit_ck_lo = adr_ok && (idx == IDX_HOST_CK_LO);
  assign hit_pwr = adr_ok && (idx == IDX_PWR_TONE);
  assign hit_aux = adr_ok && (idx == IDX_AUX_CMD);
  assign hit_calc_hi = adr_ok && (idx == IDX_CALC_CK_HI);
  assign hit_calc_lo = adr_ok && (idx == IDX_CALC_CK_LO);
  assign wbyte = wb_dat_i[7:0];
  assign wr_pwr = wr && low_lane && hit_pwr;
  assign wr_aux = wr && low_lane && hit_aux;
  assign pwr_any = wbyte[B_SOFT_RESET] || wbyte[B_POWER_DOWN] || wbyte[B_DOZE_ENTRY];

  // Read mux; unmapped addresses and reserved bits read as zero
  always_comb
  begin
    rbyte = 8'h00;
    if (hit_ck_hi)
    begin
      rbyte = st.host_ck_hi;
    end
    else if (hit_ck_lo)
    begin
      rbyte = st.host_ck_lo;
    end
    else if (hit_pwr)
    begin
      rbyte = st.pwr_tone;
    end
    else if (hit_aux)
    begin
      // Only the two defined bits of this register are backed by flops
      rbyte[B_THERM_BIAS] = st.thermistor_bias_enable;
      rbyte[B_HARD_TONE] = st.hard_reinit_tone_cmd;
    end
    else if (hit_calc_hi)
    begin
      // Computed checksum bytes are read live from the engine
      rbyte = calc_ck_hi_i;
    end
    else if (hit_calc_lo)
    begin
      rbyte = calc_ck_lo_i;
    end
  end

  always_comb
  begin
    next_st = st;
    // Ack answers one cycle after the request and drops next cycle even if the strobe stays up
    next_st.ack = req;
    next_st.tone = '0;
    next_st.power = '0;

    // Command bits live one cycle, then clear as their pulse goes out
    next_st.pwr_tone[B_SOFT_RESET] = 1'b0;
    next_st.pwr_tone[B_POWER_DOWN] = 1'b0;
    next_st.pwr_tone[B_DOZE_ENTRY] = 1'b0;
    next_st.pwr_tone[B_DOZE_TO_ACT] = 1'b0;
    // The two remaining tone bits clear the same way
    next_st.pwr_tone[B_WAKE_TONE] = 1'b0;
    next_st.pwr_tone[B_OFF_HARD_TONE] = 1'b0;

    // Read data is zero outside an acked read, so a stale byte never lingers on the bus
    if (rd)
    begin
      next_st.dat = {24'h000000, rbyte};
    end
    else
    begin
      next_st.dat = 32'h00000000;
    end

    // Issue pulses for the command latched in the previous cycle
    // Power bits outrank every tone; only soft reset adds its own wake tone
    if (st.pwr_tone[B_SOFT_RESET])
    begin
      next_st.power.soft_reset = 1'b1;
      next_st.tone.wake = 1'b1;
    end
    else if (st.pwr_tone[B_POWER_DOWN])
    begin
      next_st.power.power_down = 1'b1;
    end
    else if (st.pwr_tone[B_DOZE_ENTRY])
    begin
      next_st.power.doze_entry = 1'b1;
    end
    else if (st.pwr_tone[B_WAKE_TONE])
    begin
      next_st.tone.wake = 1'b1;
    end
    else if (st.pwr_tone[B_DOZE_TO_ACT])
    begin
      next_st.tone.doze_to_active = 1'b1;
    end
    else if (st.pwr_tone[B_OFF_HARD_TONE])
    begin
      next_st.tone.off_or_hard_reinit = 1'b1;
    end

    // Register writes; a multi-bit command keeps only its winner
    // Writes without byte lane 0 are acked but change nothing
    if (wr && low_lane && hit_ck_hi)
    begin
      next_st.host_ck_hi = wbyte;
    end
    if (wr && low_lane && hit_ck_lo)
    begin
      next_st.host_ck_lo = wbyte;
    end
    if (wr_pwr)
    begin
      // Direction and arm bits are plain stored bits, rewritten on every write
      next_st.pwr_tone[B_DIR_SEL] = wbyte[B_DIR_SEL];
      next_st.pwr_tone[B_ADDR_ARM] = wbyte[B_ADDR_ARM];
      if (wbyte[B_SOFT_RESET])
      begin
        next_st.pwr_tone[B_SOFT_RESET] = 1'b1;
      end
      else if (wbyte[B_POWER_DOWN])
      begin
        next_st.pwr_tone[B_POWER_DOWN] = 1'b1;
      end
      else if (wbyte[B_DOZE_ENTRY])
      begin
        next_st.pwr_tone[B_DOZE_ENTRY] = 1'b1;
      end
      else if (wbyte[B_WAKE_TONE])
      begin
        next_st.pwr_tone[B_WAKE_TONE] = 1'b1;
      end
      else if (wbyte[B_DOZE_TO_ACT])
      begin
        next_st.pwr_tone[B_DOZE_TO_ACT] = 1'b1;
      end
      else if (wbyte[B_OFF_HARD_TONE] && !pwr_any)
      begin
        next_st.pwr_tone[B_OFF_HARD_TONE] = 1'b1;
      end
    end

    // Read clears the hard reinit request; a write in the same access sets it
    // The tone pulse leaves at the write edge; the stored bit only reports the request
    if (rd && hit_aux)
    begin
      next_st.hard_reinit_tone_cmd = 1'b0;
    end
    if (wr_aux)
    begin
      next_st.thermistor_bias_enable = wbyte[B_THERM_BIAS];
      if (wbyte[B_HARD_TONE])
      begin
        next_st.hard_reinit_tone_cmd = 1'b1;
        next_st.tone.hard_reinit = 1'b1;
      end
    end

    // Auto-addressing: hold forwarding closed until the first transaction ends
    // Limitation: a transaction that starts before the armed state is reached is not the one held; forwarding still closes partway through it
    case (st.adr)
      ADR_IDLE:
      begin
        next_st.fwd_en = 1'b1;
        if (st.pwr_tone[B_ADDR_ARM])
        begin
          next_st.adr = ADR_ARMED;
          next_st.fwd_en = 1'b0;
        end
      end
      ADR_ARMED:
      begin
        // Clearing the arm bit before any traffic reopens at once
        next_st.fwd_en = 1'b0;
        if (!st.pwr_tone[B_ADDR_ARM])
        begin
          next_st.adr = ADR_IDLE;
          next_st.fwd_en = 1'b1;
        end
        else if (rx_start_i)
        begin
          next_st.adr = ADR_HELD;
        end
      end
      ADR_HELD:
      begin
        // Withhold until the end pulse of the transaction that is being held back
        next_st.fwd_en = 1'b0;
        if (rx_end_i)
        begin
          next_st.adr = ADR_DONE;
          next_st.fwd_en = 1'b1;
        end
      end
      ADR_DONE:
      begin
        // Open again; clearing the arm bit returns to idle and stays open, writing it set once more re-arms
        next_st.fwd_en = 1'b1;
        if (!st.pwr_tone[B_ADDR_ARM])
        begin
          next_st.adr = ADR_IDLE;
        end
      end
      default:
      begin
        next_st.adr = ADR_IDLE;
        next_st.fwd_en = 1'b1;
      end
    endcase

    // A fresh write of the arm bit re-arms for one more withheld transaction
    if (wr_pwr && wbyte[B_ADDR_ARM] && (st.adr == ADR_DONE))
    begin
      next_st.adr = ADR_ARMED;
      next_st.fwd_en = 1'b0;
    end

    // Soft reset reloads defaults; its pulses above still go out
    // The reload overrides any write in the same cycle
    if (st.pwr_tone[B_SOFT_RESET])
    begin
      next_st.host_ck_hi = HOST_CK_HI_DEF;
      next_st.host_ck_lo = HOST_CK_LO_DEF;
      next_st.pwr_tone = RST_CMD;
      next_st.thermistor_bias_enable = 1'b0;
      next_st.hard_reinit_tone_cmd = 1'b0;
      next_st.adr = ADR_IDLE;
      next_st.fwd_en = 1'b1;
    end
  end

  // Synchronous reset only; its values match the soft reset reload
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.host_ck_hi <= HOST_CK_HI_DEF;
      st.host_ck_lo <= HOST_CK_LO_DEF;
      st.pwr_tone <= RST_CMD;
      st.adr <= ADR_IDLE;
      st.fwd_en <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output is a field of the registered state
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign forward_en_o = st.fwd_en;
  assign tone_o = st.tone;
  assign power_o = st.power;
  assign thermistor_bias_enable_o = st.thermistor_bias_enable;
  assign dir_sel_o = st.pwr_tone[B_DIR_SEL];
  assign host_ck_hi_o = st.host_ck_hi;
  assign host_ck_lo_o = st.host_ck_lo;

endmodule : ptc_regs

/* File: common/ptc_pkg.sv */
// Package of the power and tone command register bank.
// Assumes Wishbone classic byte addresses with one 32-bit word per register.
package ptc_pkg;
  localparam int ADR_W = 16;
  localparam int IDX_W = 12;
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_HOST_CK_HI = 12'h036;
  localparam logic [IDX_W-1:0] IDX_HOST_CK_LO = 12'h037;
  localparam logic [IDX_W-1:0] IDX_PWR_TONE = 12'h309;
  localparam logic [IDX_W-1:0] IDX_AUX_CMD = 12'h30a;
  localparam logic [IDX_W-1:0] IDX_CALC_CK_HI = 12'h50c;
  localparam logic [IDX_W-1:0] IDX_CALC_CK_LO = 12'h50d;
  // power_tone_command fields
  localparam int B_ADDR_ARM = 0;
  localparam int B_SOFT_RESET = 1;
  localparam int B_DOZE_ENTRY = 2;
  localparam int B_POWER_DOWN = 3;
  localparam int B_DOZE_TO_ACT = 4;
  localparam int B_WAKE_TONE = 5;
  localparam int B_OFF_HARD_TONE = 6;
  localparam int B_DIR_SEL = 7;
  // aux_command fields
  localparam int B_THERM_BIAS = 4;
  localparam int B_HARD_TONE = 5;
  // Reset values
  localparam logic [7:0] RST_HOST_CK_HI = 8'h2b;
  localparam logic [7:0] RST_HOST_CK_LO = 8'h89;
  localparam logic [7:0] RST_CMD = 8'h00;

  typedef enum logic [1:0] {
    ADR_IDLE = 2'b00,
    ADR_ARMED = 2'b01,
    ADR_HELD = 2'b10,
    ADR_DONE = 2'b11
  } ptc_adr_t;

  typedef struct packed {
    logic wake;
    logic doze_to_active;
    logic off_or_hard_reinit;
    logic hard_reinit;
  } ptc_tone_t;

  typedef struct packed {
    logic soft_reset;
    logic power_down;
    logic doze_entry;
  } ptc_power_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [7:0] host_ck_hi;
    logic [7:0] host_ck_lo;
    logic [7:0] pwr_tone;
    logic thermistor_bias_enable;
    logic hard_reinit_tone_cmd;
    ptc_adr_t adr;
    logic fwd_en;
    ptc_tone_t tone;
    ptc_power_t power;
  } ptc_state_t;
endpackage : ptc_pkg

/* File: dv/ptc_regs_monitor.sv */
// Checker of the command register bank, bound to ptc_regs.
// Assumes byte addresses of index times four and one write lane.
`timescale 1ns/1ps
module ptc_regs_monitor
  import ptc_pkg::*;
#(
  parameter logic [7:0] HOST_CK_HI_DEF = RST_HOST_CK_HI,
  parameter logic [7:0] HOST_CK_LO_DEF = RST_HOST_CK_LO
)
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [ADR_W-1:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [7:0] calc_ck_hi_i, // Engine high byte
  input wire logic rx_end_i, // Transaction end
  input wire logic forward_en_o, // Forwarding
  input wire ptc_tone_t tone_o, // Tones
  input wire ptc_power_t power_o, // Power pulses
  input wire logic thermistor_bias_enable_o, // Bias
  input wire logic [7:0] host_ck_hi_o, // Host high
  input wire logic [7:0] host_ck_lo_o // Host low
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic wr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  a_ack_pulse: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  a_soft_wake: assert property (power_o.soft_reset |-> tone_o.wake) else $error("no wake");
  a_soft_reload: assert property (power_o.soft_reset |-> host_ck_hi_o == HOST_CK_HI_DEF
    && host_ck_lo_o == HOST_CK_LO_DEF && !thermistor_bias_enable_o) else $error("no reload");
  a_power_rank: assert property ($onehot0(power_o)) else $error("two power pulses");
  a_power_first: assert property ((power_o.power_down || power_o.doze_entry) |-> !(tone_o.wake
    || tone_o.doze_to_active || tone_o.off_or_hard_reinit)) else $error("tone beat power");
  a_down_cmd: assert property (wr && wb_adr_i == {2'h0, IDX_PWR_TONE, 2'h0} && wb_dat_i[3:1] == 3'h4
    |-> ##2 power_o.power_down ##1 !power_o.power_down) else $error("power down pulse");
  a_hard_tone: assert property (wr && wb_adr_i == {2'h0, IDX_AUX_CMD, 2'h0} && wb_dat_i[5]
    |=> tone_o.hard_reinit) else $error("no hard tone");
  a_bias_follow: assert property (wr && wb_adr_i == {2'h0, IDX_AUX_CMD, 2'h0}
    |=> thermistor_bias_enable_o == $past(wb_dat_i[4])) else $error("bias");
  a_ck_hi_wr: assert property (wr && wb_adr_i == {2'h0, IDX_HOST_CK_HI, 2'h0}
    |=> host_ck_hi_o == $past(wb_dat_i[7:0])) else $error("host high");
  a_ck_lo_wr: assert property (wr && wb_adr_i == {2'h0, IDX_HOST_CK_LO, 2'h0}
    |=> host_ck_lo_o == $past(wb_dat_i[7:0])) else $error("host low");
  a_calc_read: assert property (req && !wb_we_i && wb_adr_i == {2'h0, IDX_CALC_CK_HI, 2'h0}
    |=> wb_dat_o == {24'h000000, $past(calc_ck_hi_i)}) else $error("calc high");
  a_fwd_resume: assert property (!forward_en_o && rx_end_i && !req |=> forward_en_o)
    else $error("no resume");
  c_soft: cover property (power_o.soft_reset);
  c_hard: cover property (tone_o.hard_reinit);
  c_held: cover property (!forward_en_o && rx_end_i);
endmodule : ptc_regs_monitor

bind ptc_regs ptc_regs_monitor #(.HOST_CK_HI_DEF(HOST_CK_HI_DEF), .HOST_CK_LO_DEF(HOST_CK_LO_DEF)) u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .calc_ck_hi_i, .rx_end_i, .forward_en_o, .tone_o, .power_o, .thermistor_bias_enable_o, .host_ck_hi_o,
  .host_ck_lo_o);

/* File: dv/ptc_link_model.sv */
// Model of the chain link and checksum engine beside the bank.
// Assumes send_i is a one-cycle request from the bench.
`timescale 1ns/1ps
module ptc_link_model #(
  parameter int LEN = 4,
  parameter logic [7:0] CK_HI = 8'h5a, // Arbitrary
  parameter logic [7:0] CK_LO = 8'ha5 // Arbitrary
)
(
  input wire logic clk_i, // Clock
  input wire logic send_i, // Start a transaction
  output logic rx_start_o, // Start pulse
  output logic rx_end_o, // End pulse
  output logic [7:0] ck_hi_o, // Engine high byte
  output logic [7:0] ck_lo_o // Engine low byte
);
  int cnt = 0;
  initial rx_start_o = 1'b0;
  initial rx_end_o = 1'b0;
  assign ck_hi_o = CK_HI;
  assign ck_lo_o = CK_LO;
  // A transaction spans LEN cycles from start pulse to end pulse
  always @(posedge clk_i)
  begin
    rx_start_o <= send_i;
    rx_end_o <= (cnt == 1);
    cnt <= send_i ? LEN : (cnt != 0 ? cnt - 1 : 0);
  end
endmodule : ptc_link_model

/* File: dv/ptc_regs_tb_top.sv */
// Self-checking bench of the command register bank.
// Assumes the link model drives the receive pulses and checksum bytes.
`timescale 1ns/1ps
module ptc_regs_tb_top;
  import ptc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic send = 1'b0;
  logic clr = 1'b0;
  logic rxs, rxe, fwd, bias;
  logic [7:0] ckh, ckl;
  logic [7:0] hckh, hckl;
  logic dir;
  ptc_tone_t tone;
  ptc_power_t pwr;
  logic [6:0] seen = 7'h00;
  int miscompares = 0;
  int check_count = 0;
  // Single-bit writes first, then combined ones resolved by rank
  // Entries 0 to 5 set one command bit each as the host must
  logic [7:0] cmd_tab [0:10] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h7e, 8'h0c, 8'h70, 8'h50, 8'h48};
  logic [6:0] exp_tab [0:10] = '{7'h48, 7'h10, 7'h20, 7'h04, 7'h08, 7'h02, 7'h48, 7'h20, 7'h08, 7'h04, 7'h20};
  ptc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .calc_ck_hi_i(ckh), .calc_ck_lo_i(ckl),
    .rx_start_i(rxs), .rx_end_i(rxe), .forward_en_o(fwd), .tone_o(tone), .power_o(pwr),
    .thermistor_bias_enable_o(bias), .dir_sel_o(dir), .host_ck_hi_o(hckh), .host_ck_lo_o(hckl));
  ptc_link_model u_link (.clk_i(clk_i), .send_i(send), .rx_start_o(rxs), .rx_end_o(rxe), .ck_hi_o(ckh),
    .ck_lo_o(ckl));
  initial forever #2.5 clk_i = ~clk_i;
  // Pulses are collected so a one-cycle output is never missed
  always @(posedge clk_i) seen <= clr ? 7'h00 : (seen | {pwr, tone});
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d, output logic [7:0] q);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'h0, idx, 2'h0};
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic clr_seen;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask : clr_seen
  task automatic t_checksums;
    rd(IDX_HOST_CK_HI, RST_HOST_CK_HI);
    rd(IDX_HOST_CK_LO, RST_HOST_CK_LO);
    wr(IDX_HOST_CK_HI, 8'h3c);
    chk(hckh, 8'h3c);
    rd(IDX_HOST_CK_HI, 8'h3c);
    wr(IDX_HOST_CK_LO, 8'hc3);
    chk(hckl, 8'hc3);
    rd(IDX_HOST_CK_LO, 8'hc3);
    rd(IDX_CALC_CK_HI, 8'h5a);
    wr(IDX_CALC_CK_LO, 8'h00);
    rd(IDX_CALC_CK_LO, 8'ha5);
    rd(12'h123, 8'h00);
  endtask : t_checksums
  task automatic t_bias_soft;
    wr(IDX_AUX_CMD, 8'h10);
    chk({7'h00, bias}, 8'h01);
    wr(IDX_AUX_CMD, 8'h00);
    chk({7'h00, bias}, 8'h00);
    wr(IDX_AUX_CMD, 8'h10);
    wr(IDX_PWR_TONE, 8'h02);
    rd(IDX_HOST_CK_LO, RST_HOST_CK_LO);
    chk(hckh, RST_HOST_CK_HI);
    chk({7'h00, bias}, 8'h00);
  endtask : t_bias_soft
  task automatic t_commands;
    for (int i = 0; i < 11; i++)
    begin
      clr_seen();
      wr(IDX_PWR_TONE, cmd_tab[i]);
      repeat (3) @(posedge clk_i);
      chk({1'b0, seen}, {1'b0, exp_tab[i]});
      rd(IDX_PWR_TONE, 8'h00);
    end
  endtask : t_commands
  task automatic t_hard;
    clr_seen();
    wr(IDX_AUX_CMD, 8'h20);
    repeat (2) @(posedge clk_i);
    chk({1'b0, seen}, 8'h01);
    rd(IDX_AUX_CMD, 8'h20);
    rd(IDX_AUX_CMD, 8'h00);
  endtask : t_hard
  task automatic txn(input logic [7:0] mid, input logic [7:0] fin);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({7'h00, fwd}, mid);
    repeat (5) @(posedge clk_i);
    chk({7'h00, fwd}, fin);
  endtask : txn
  task automatic t_addr;
    wr(IDX_PWR_TONE, 8'h81);
    chk({7'h00, fwd}, 8'h00);
    chk({7'h00, dir}, 8'h01);
    txn(8'h00, 8'h01);
    wr(IDX_PWR_TONE, 8'h81);
    chk({7'h00, fwd}, 8'h00);
    txn(8'h00, 8'h01);
    wr(IDX_PWR_TONE, 8'h00);
    chk({7'h00, dir}, 8'h00);
    txn(8'h01, 8'h01);
  endtask : t_addr
  initial
  begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({7'h00, fwd}, 8'h01);
    t_checksums();
    t_bias_soft();
    t_commands();
    t_hard();
    t_addr();
    stop_test();
  end
endmodule : ptc_regs_tb_top
